/* File: core/dss_sequencer.sv */
// Start and stop sequencer for a motor drive, with APB settings
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dss_sequencer #(
  parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES,
  parameter int SPEED_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_cmd,
  input wire logic [SPEED_W-1:0] ref_speed,
  input wire logic [SPEED_W-1:0] detected_speed,
  output logic [SPEED_W-1:0] final_ref_speed,
  output logic output_on,
  output logic dc_brake_on,
  output logic [6:0] dc_brake_current_level_out,
  output logic torque_start_on,
  output logic [15:0] torque_level,
  output logic [3:0] phase_code
);
  // Settings
  logic [1:0] control_mode, speed_source_select;
  logic start_mode_select, stop_detect_select;
  logic [15:0] starting_speed, stop_speed, dc_brake_start_speed;
  logic [6:0] dc_brake_current_level;
  logic [15:0] starting_hold_time, zero_speed_hold_time, dc_brake_duration;
  logic [15:0] soft_start_period, stop_hold_time;
  // Sequencer state
  dss_pkg::dss_phase_t phase, next_phase;
  logic [15:0] phase_cnt, ramp_cnt;
  logic run_meta, run_sync, run_armed, tick;
  // Decoded conditions
  logic wr_en, rd_setup, is_vector, go_ref;
  logic below_stop, below_brake, brake_allowed;
  logic [15:0] ref_eff, stop_sense, brake_speed;
  logic [31:0] soft_val;

  // Clamp a written value to its documented maximum
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction : clamp16
  // Known address test, used for the error answer to reads and writes
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == dss_pkg::ADDR_CTRL) || (a == dss_pkg::ADDR_SPEED) ||
             (a == dss_pkg::ADDR_BRAKE) || (a == dss_pkg::ADDR_HOLD) ||
             (a == dss_pkg::ADDR_TIME) || (a == dss_pkg::ADDR_STOP) ||
             (a == dss_pkg::ADDR_STATUS);
  endfunction : mapped
  // Tick source for every phase duration
  dss_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );
  // Run arrives from a pin, so two flops before any use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {run_sync, run_meta} <= 2'b00;
    else
      {run_sync, run_meta} <= {run_meta, run_cmd};
  end
  // Bus strobes: setup cycle and the write access edge
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  // APB: one wait-free access phase, pready raised by the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped(paddr);
      if (rd_setup && !pwrite)
      begin
        unique case (paddr)
          dss_pkg::ADDR_CTRL: prdata <= {26'h0, stop_detect_select,
            start_mode_select, speed_source_select, control_mode};
          dss_pkg::ADDR_SPEED: prdata <= {stop_speed, starting_speed};
          dss_pkg::ADDR_BRAKE: prdata <= {9'h000, dc_brake_current_level,
            dc_brake_start_speed};
          dss_pkg::ADDR_HOLD: prdata <= {zero_speed_hold_time,
            starting_hold_time};
          dss_pkg::ADDR_TIME: prdata <= {soft_start_period,
            dc_brake_duration};
          dss_pkg::ADDR_STOP: prdata <= {16'h0000, stop_hold_time};
          dss_pkg::ADDR_STATUS: prdata <= {phase_cnt, 9'h000, run_armed,
            run_sync, output_on, phase};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Settings take effect at the access edge; out-of-range speeds, times and brake level clamp, CTRL fields are stored as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_mode <= dss_pkg::RESET_CTRL[1:0];
      speed_source_select <= dss_pkg::RESET_CTRL[3:2];
      start_mode_select <= 1'b0;
      stop_detect_select <= 1'b0;
      starting_speed <= dss_pkg::RESET_SETTING;
      stop_speed <= dss_pkg::RESET_SETTING;
      dc_brake_start_speed <= dss_pkg::RESET_SETTING;
      dc_brake_current_level <= 7'h00;
      starting_hold_time <= dss_pkg::RESET_SETTING;
      zero_speed_hold_time <= dss_pkg::RESET_SETTING;
      dc_brake_duration <= dss_pkg::RESET_SETTING;
      soft_start_period <= dss_pkg::RESET_SETTING;
      stop_hold_time <= dss_pkg::RESET_SETTING;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        dss_pkg::ADDR_CTRL:
        begin
          control_mode <= pwdata[dss_pkg::CTRL_MODE_LSB +: 2];
          speed_source_select <= pwdata[dss_pkg::CTRL_SRC_LSB +: 2];
          start_mode_select <= pwdata[dss_pkg::CTRL_START_MODE];
          stop_detect_select <= pwdata[dss_pkg::CTRL_STOP_DET];
        end
        dss_pkg::ADDR_SPEED:
        begin
          starting_speed <= clamp16(pwdata[15:0], dss_pkg::MAX_SPEED);
          stop_speed <= clamp16(pwdata[31:16], dss_pkg::MAX_SPEED);
        end
        dss_pkg::ADDR_BRAKE:
        begin
          dc_brake_start_speed <= clamp16(pwdata[15:0],
                                          dss_pkg::MAX_SPEED);
          dc_brake_current_level <= 7'(clamp16(16'(pwdata[22:16]),
            16'(dss_pkg::MAX_BRAKE_LEVEL)));
        end
        dss_pkg::ADDR_HOLD:
        begin
          starting_hold_time <= clamp16(pwdata[15:0],
                                        dss_pkg::MAX_HOLD_TIME);
          zero_speed_hold_time <= clamp16(pwdata[31:16],
                                          dss_pkg::MAX_HOLD_TIME);
        end
        dss_pkg::ADDR_TIME:
        begin
          dc_brake_duration <= clamp16(pwdata[15:0],
                                       dss_pkg::MAX_BRAKE_TIME);
          soft_start_period <= clamp16(pwdata[31:16],
                                       dss_pkg::MAX_SOFT_TIME);
        end
        dss_pkg::ADDR_STOP:
          stop_hold_time <= clamp16(pwdata[15:0],
                                    dss_pkg::MAX_HOLD_TIME);
        default: ;
      endcase
    end
  end
  // Condition decode for the phase machine
  assign is_vector = (control_mode != dss_pkg::MODE_TORQUE_VEC);
  assign ref_eff = (ref_speed < stop_speed) ? 16'h0000 : ref_speed;
  assign stop_sense = stop_detect_select ? final_ref_speed :
                      detected_speed;
  // Reference must pass the starting speed and, if higher, the stop speed
  assign go_ref = (ref_eff > starting_speed) &&
                  (ref_eff > stop_speed);
  assign below_stop = (stop_sense < stop_speed);
  assign brake_speed = (stop_speed > dc_brake_start_speed) ? stop_speed :
                       dc_brake_start_speed;
  assign below_brake = (stop_sense < brake_speed);
  assign brake_allowed = !is_vector && (dc_brake_duration != 16'h0000);
  // Ramps restart from zero on entry; the old phase's count would jump
  assign ramp_cnt = (next_phase != phase) ? 16'h0000 : phase_cnt;
  // Linear soft start profile; capped, so the divisor is never zero
  assign soft_val = (ramp_cnt >= soft_start_period) ? 32'(starting_speed) :
    (32'(starting_speed) * 32'(ramp_cnt)) / 32'(soft_start_period);
  // Phase after start delays: torque start, soft start or direct wait
  function automatic dss_pkg::dss_phase_t soft_entry(input logic [1:0] src,
                                                     input logic tmode,
                                                     input logic vec,
                                                     input logic [15:0] ss);
    if (src == dss_pkg::SRC_ANALOG_REV)
      soft_entry = dss_pkg::PH_WAIT_REF;
    else if (tmode && vec && (src == dss_pkg::SRC_MULTISTEP) &&
             (ss != 16'h0000))
      soft_entry = dss_pkg::PH_TORQUE_START;
    else
      soft_entry = dss_pkg::PH_SOFT_START;
  endfunction : soft_entry
  // Phase machine
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      dss_pkg::PH_IDLE:
        if (run_sync && run_armed &&
            ((speed_source_select != dss_pkg::SRC_MULTISTEP) || go_ref))
        begin
          if (speed_source_select == dss_pkg::SRC_ANALOG_REV)
            next_phase = dss_pkg::PH_WAIT_REF;
          else if (zero_speed_hold_time != 16'h0000)
            next_phase = is_vector ? dss_pkg::PH_ZERO_HOLD :
                         dss_pkg::PH_START_DCB;
          else
            next_phase = soft_entry(speed_source_select, start_mode_select,
                                    is_vector, starting_speed);
        end
      dss_pkg::PH_START_DCB, dss_pkg::PH_ZERO_HOLD:
        if (!run_sync)
          next_phase = dss_pkg::PH_STOP_HOLD;
        else if (phase_cnt >= zero_speed_hold_time)
          next_phase = soft_entry(speed_source_select, start_mode_select,
                                  is_vector, starting_speed);
      dss_pkg::PH_SOFT_START:
        if (!run_sync)
          next_phase = dss_pkg::PH_STOP_HOLD;
        else if (phase_cnt >= soft_start_period)
          next_phase = (speed_source_select == dss_pkg::SRC_MULTISTEP) ?
                       dss_pkg::PH_START_HOLD :
                       dss_pkg::PH_WAIT_REF;
      dss_pkg::PH_START_HOLD:
        if (!run_sync)
          next_phase = dss_pkg::PH_STOP_HOLD;
        else if (phase_cnt >= starting_hold_time)
          next_phase = dss_pkg::PH_RUN;
      dss_pkg::PH_WAIT_REF:
        if (!run_sync)
          next_phase = dss_pkg::PH_STOP_HOLD;
        else if (go_ref)
          next_phase = dss_pkg::PH_RUN;
      dss_pkg::PH_TORQUE_START:
        if (!run_sync)
          next_phase = dss_pkg::PH_STOP_HOLD;
        else if (detected_speed > starting_speed)
          next_phase = dss_pkg::PH_RUN;
      dss_pkg::PH_RUN:
        // With run held the machine stays here even at low speed
        if (!run_sync && brake_allowed && below_brake)
          next_phase = dss_pkg::PH_STOP_DCB;
        else if (!run_sync && below_stop)
          next_phase = dss_pkg::PH_STOP_HOLD;
      dss_pkg::PH_STOP_HOLD:
        if (run_sync)
          next_phase = dss_pkg::PH_RUN;
        else if (phase_cnt >= stop_hold_time)
          next_phase = dss_pkg::PH_IDLE;
      dss_pkg::PH_STOP_DCB:
        if (phase_cnt >= dc_brake_duration)
          next_phase = dss_pkg::PH_IDLE;
      default: next_phase = dss_pkg::PH_IDLE;
    endcase
  end
  // Phase register and tick counter restarted on every phase change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= dss_pkg::PH_IDLE;
      phase_cnt <= 16'h0000;
    end
    else
    begin
      phase <= next_phase;
      if (next_phase != phase)
        phase_cnt <= 16'h0000;
      else if (tick && (phase_cnt != 16'hFFFF))
        phase_cnt <= phase_cnt + 16'h0001;
    end
  end
  // A new start needs run to have been seen low after the last stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_armed <= 1'b1;
    else if (!run_sync)
      run_armed <= 1'b1;
    else if (phase != dss_pkg::PH_IDLE)
      run_armed <= 1'b0;
  end
  // Drive outputs, all registered from the next phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      final_ref_speed <= '0;
      output_on <= 1'b0;
      dc_brake_on <= 1'b0;
      dc_brake_current_level_out <= 7'h00;
      torque_start_on <= 1'b0;
      torque_level <= 16'h0000;
      phase_code <= 4'h0;
    end
    else
    begin
      phase_code <= next_phase;
      output_on <= (next_phase != dss_pkg::PH_IDLE);
      dc_brake_on <= (next_phase == dss_pkg::PH_START_DCB) ||
                     (next_phase == dss_pkg::PH_STOP_DCB);
      dc_brake_current_level_out <=
        ((next_phase == dss_pkg::PH_START_DCB) ||
         (next_phase == dss_pkg::PH_STOP_DCB)) ?
        dc_brake_current_level : 7'h00;
      torque_start_on <= (next_phase == dss_pkg::PH_TORQUE_START);
      // Torque slope: full scale reached after the starting hold time
      if (next_phase != dss_pkg::PH_TORQUE_START)
        torque_level <= 16'h0000;
      else if (ramp_cnt >= starting_hold_time)
        torque_level <= dss_pkg::TORQUE_FULL;
      else
        torque_level <= 16'((32'(dss_pkg::TORQUE_FULL) *
          32'(ramp_cnt)) / 32'(starting_hold_time));
      unique case (next_phase)
        dss_pkg::PH_SOFT_START:
          final_ref_speed <= SPEED_W'(soft_val);
        dss_pkg::PH_START_HOLD:
          final_ref_speed <= SPEED_W'(starting_speed);
        dss_pkg::PH_WAIT_REF:
          // Reverse source waits at zero; forward holds starting speed
          final_ref_speed <= (speed_source_select ==
            dss_pkg::SRC_ANALOG_REV) ? '0 : SPEED_W'(starting_speed);
        dss_pkg::PH_TORQUE_START:
          final_ref_speed <= detected_speed;
        dss_pkg::PH_RUN:
          // Downstream ramp does the deceleration when run drops
          final_ref_speed <= run_sync ? SPEED_W'(ref_eff) : '0;
        default: final_ref_speed <= '0;
      endcase
    end
  end
endmodule : dss_sequencer

/* File: core/dss_pkg.sv */
// Shared constants for the drive start/stop sequencer
package dss_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SPEED = 8'h04;
  localparam logic [7:0] ADDR_BRAKE = 8'h08;
  localparam logic [7:0] ADDR_HOLD = 8'h0C;
  localparam logic [7:0] ADDR_TIME = 8'h10;
  localparam logic [7:0] ADDR_STOP = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // CTRL field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_START_MODE = 4;
  localparam int CTRL_STOP_DET = 5;
  // Control modes
  localparam logic [1:0] MODE_VEC_ASYNC = 2'h0;
  localparam logic [1:0] MODE_VEC_SYNC = 2'h1;
  localparam logic [1:0] MODE_TORQUE_VEC = 2'h2;
  // Speed command sources
  localparam logic [1:0] SRC_MULTISTEP = 2'h0;
  localparam logic [1:0] SRC_ANALOG_FWD = 2'h1;
  localparam logic [1:0] SRC_ANALOG_REV = 2'h2;
  // Setting limits: speeds in 0.1 r/min, times in 10 ms ticks
  localparam logic [15:0] MAX_SPEED = 16'h05DC;
  localparam logic [6:0] MAX_BRAKE_LEVEL = 7'h32;
  localparam logic [15:0] MAX_BRAKE_TIME = 16'h0BB8;
  localparam logic [15:0] MAX_HOLD_TIME = 16'h03E8;
  localparam logic [15:0] MAX_SOFT_TIME = 16'h1770;
  // Reset values of all settings
  localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
  localparam logic [15:0] RESET_SETTING = 16'h0000;
  // Tick base: 10 ms at 200 MHz
  localparam int TICK_MS = 10;
  localparam int CLK_MHZ = 200;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  // Full-scale torque ramp value
  localparam logic [15:0] TORQUE_FULL = 16'hFFFF;
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_START_DCB,
    PH_ZERO_HOLD,
    PH_SOFT_START,
    PH_START_HOLD,
    PH_WAIT_REF,
    PH_TORQUE_START,
    PH_RUN,
    PH_STOP_HOLD,
    PH_STOP_DCB
  } dss_phase_t;
endpackage : dss_pkg

/* File: core/dss_tick.sv */
// Ten-millisecond tick generator for phase timing
`timescale 1ns/1ps
module dss_tick #(
  parameter int CYCLES = dss_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [31:0] count;

  // Free-running divider; one-cycle pulse at each wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (count == 32'(CYCLES - 1))
    begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : dss_tick

/* File: testbench/dss_seq_asserts.sv */
// Checker for the sequencer phases, drive outputs and bus handshake
`timescale 1ns/1ps
module dss_seq_asserts #(
  parameter int SPEED_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SPEED_W-1:0] final_ref_speed,
  input wire logic output_on,
  input wire logic dc_brake_on,
  input wire logic [6:0] dc_brake_current_level_out,
  input wire logic torque_start_on,
  input wire logic [15:0] torque_level,
  input wire logic [3:0] phase_code
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answers one cycle after setup and never stretches
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_brake_level_cap: assert property (dc_brake_on |->
    dc_brake_current_level_out <= 7'h32) else $error("brake level high");
  a_brake_level_off: assert property (!dc_brake_on |->
    dc_brake_current_level_out == 7'h00) else $error("level without brake");
  a_brake_in_phase: assert property (dc_brake_on ==
    (phase_code == 4'h1 || phase_code == 4'h9)) else $error("brake phase");
  a_output_follows: assert property (output_on ==
    (phase_code != 4'h0)) else $error("output enable wrong");
  a_torque_gated: assert property (!torque_start_on |->
    torque_level == 16'h0000) else $error("torque outside start");
  a_torque_rises: assert property (torque_start_on && $past(torque_start_on)
    |-> torque_level >= $past(torque_level))
    else $error("torque ramp fell");
  a_soft_ramp_up: assert property ((phase_code == 4'h3) ##1
    (phase_code == 4'h3) |-> final_ref_speed >= $past(final_ref_speed))
    else $error("soft start ramp fell");
  a_idle_exit: assert property ((phase_code == 4'h0) ##1
    (phase_code != 4'h0) |-> phase_code inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6})
    else $error("bad phase after idle");
  a_soft_exit: assert property ((phase_code == 4'h3) ##1
    (phase_code != 4'h3) |-> phase_code inside {4'h4, 4'h5, 4'h8})
    else $error("bad phase after soft start");
  a_run_no_restart: assert property ((phase_code == 4'h7) ##1
    (phase_code != 4'h7) |-> phase_code inside {4'h8, 4'h9})
    else $error("run left for a start phase");
  a_stop_brake_end: assert property ((phase_code == 4'h9) ##1
    (phase_code != 4'h9) |-> phase_code == 4'h0)
    else $error("stop braking not ended in idle");

  // Main scenarios reached
  c_stop_brake: cover property (phase_code == 4'h9);
  c_start_brake: cover property (phase_code == 4'h1);
  c_torque_start: cover property (phase_code == 4'h6);
  c_bus_error: cover property (pslverr);
endmodule : dss_seq_asserts

bind dss_sequencer dss_seq_asserts #(.SPEED_W(SPEED_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .final_ref_speed(final_ref_speed),
  .output_on(output_on), .dc_brake_on(dc_brake_on),
  .dc_brake_current_level_out(dc_brake_current_level_out),
  .torque_start_on(torque_start_on), .torque_level(torque_level),
  .phase_code(phase_code)
);

/* File: testbench/dss_ctrl_model.sv */
// Lift controller model driving run and speed, with a simple motor
`timescale 1ns/1ps
module dss_ctrl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [15:0] target,
  input wire logic [15:0] final_ref_speed,
  input wire logic torque_start_on,
  output logic run_cmd,
  output logic [15:0] ref_speed,
  output logic [15:0] detected_speed
);
  // Run follows the request; each new start comes after a low run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cmd <= 1'b0;
      ref_speed <= 16'h0000;
    end
    else
    begin
      run_cmd <= go;
      ref_speed <= target;
    end
  end

  // Motor spins up under start torque, else tracks the final reference
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      detected_speed <= 16'h0000;
    else if (torque_start_on)
      detected_speed <= detected_speed + 16'h0010;
    else
      detected_speed <= final_ref_speed;
  end
endmodule : dss_ctrl_model

/* File: testbench/test_drive_start_stop_sequencer.sv */
// Self-checking bench for the drive start/stop sequencer
`timescale 1ns/1ps
module test_drive_start_stop_sequencer;
  localparam int TK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
  logic run_cmd, output_on, dc_brake_on, torque_start_on, t, z, d;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, cfg;
  logic [15:0] ref_speed, detected_speed, final_ref_speed, torque_level;
  logic [15:0] target, ss, stop, hi, bst;
  logic [6:0] brake_lvl, lvl, lvl_e;
  logic [3:0] phase_code, last_ph;
  logic [1:0] m, s;
  logic [63:0] trace;
  logic [31:0] seed = 32'h9915;
  int error_cnt = 0;
  int check_count = 0;

  dss_sequencer #(.TICK_CYCLES(TK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .ref_speed(ref_speed), .detected_speed(detected_speed),
    .final_ref_speed(final_ref_speed), .output_on(output_on),
    .dc_brake_on(dc_brake_on), .dc_brake_current_level_out(brake_lvl),
    .torque_start_on(torque_start_on), .torque_level(torque_level),
    .phase_code(phase_code));

  dss_ctrl_model u_ctrl (
    .pclk(pclk), .presetn(presetn), .go(go), .target(target),
    .final_ref_speed(final_ref_speed), .torque_start_on(torque_start_on),
    .run_cmd(run_cmd), .ref_speed(ref_speed),
    .detected_speed(detected_speed));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task close_out;
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Xorshift source; fixed start keeps runs repeatable
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Phases expected from run to idle, four bits per visited phase
  function automatic logic [63:0] exp_trace(input logic [1:0] mo, sr,
    input logic tm, zh, du, input logic [15:0] st);
    logic [63:0] q;
    logic tv;
    tv = (mo == dss_pkg::MODE_TORQUE_VEC);
    q = 64'h0;
    if (sr == dss_pkg::SRC_ANALOG_REV)
      q = 64'h5;
    else
    begin
      if (zh)
        q = tv ? 64'h1 : 64'h2;
      if (sr == dss_pkg::SRC_MULTISTEP && !tv && tm && st != 16'h0)
        q = {q[59:0], 4'h6};
      else
        q = {q[55:0], 4'h3, (sr == dss_pkg::SRC_MULTISTEP) ? 4'h4 : 4'h5};
    end
    q = {q[55:0], 4'h7, (tv && du) ? 4'h9 : 4'h8};
    return q;
  endfunction : exp_trace

  // One bus transfer; held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rdo);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdo = prdata;
    check(64'(pslverr), 64'(a > dss_pkg::ADDR_STATUS));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_phase(input logic [3:0] p);
    int n;
    n = 0;
    while (phase_code !== p && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    check(64'(n >= 2000), 64'h0);
  endtask : wait_phase

  // Records every phase change except into idle and watches the braking current level
  always @(posedge pclk)
  begin
    if (phase_code !== last_ph && phase_code !== 4'h0)
      trace <= {trace[59:0], phase_code};
    last_ph <= phase_code;
    if (dc_brake_on === 1'b1)
      check(64'(brake_lvl), 64'(lvl_e));
  end

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, go} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    target = 16'h0;
    trace = 64'h0;
    lvl_e = 7'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dss_pkg::ADDR_CTRL, 32'h0, rd);
    check(64'(rd), 64'(dss_pkg::RESET_CTRL));
    apb(1'b1, dss_pkg::ADDR_BRAKE, 32'h007F_FFFF, rd);
    apb(1'b0, dss_pkg::ADDR_BRAKE, 32'h0, rd);
    check(64'(rd), 64'h0032_05DC);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
    apb(1'b0, 8'h1C, 32'h0, rd);
    check(64'(rd), 64'h0);
    apb(1'b1, dss_pkg::ADDR_STATUS, 32'hFFFF_FFFF, rd);
    apb(1'b0, dss_pkg::ADDR_STATUS, 32'h0, rd);
    check(64'(rd & 32'h0000_00FF), 64'h40);
    // Every mode against every source, then the same with torque start
    for (int i = 0; i < 18; i++)
    begin
      r = xs();
      m = 2'(i % 3);
      s = 2'((i / 3) % 3);
      t = (i >= 9);
      z = r[0];
      d = r[1];
      ss = (i == 10) ? 16'h0000 : {8'h00, r[23:16]};
      stop = {8'h00, r[31:24]} + 16'h0001;
      hi = {8'h02, r[9:2]};
      bst = {8'h00, r[11:4]};
      lvl = {1'b0, r[21:16]};
      lvl_e = (lvl > 7'h32) ? 7'h32 : lvl;
      cfg = {26'h0, r[3], t, s, m};
      apb(1'b1, dss_pkg::ADDR_CTRL, cfg, rd);
      apb(1'b1, dss_pkg::ADDR_SPEED, {stop, ss}, rd);
      apb(1'b1, dss_pkg::ADDR_BRAKE, {9'h0, lvl, bst}, rd);
      apb(1'b1, dss_pkg::ADDR_HOLD, {15'h0, z, 15'h0, r[12]}, rd);
      apb(1'b1, dss_pkg::ADDR_TIME, {14'h0, r[14:13], 15'h0, d}, rd);
      apb(1'b1, dss_pkg::ADDR_STOP, {16'h0, 14'h0, r[16:15]}, rd);
      apb(1'b0, dss_pkg::ADDR_CTRL, 32'h0, rd);
      check(64'(rd), 64'(cfg));
      // Reference equal to stop speed never counts as a start request
      trace <= 64'h0;
      target <= stop;
      go <= 1'b1;
      repeat (12 * TK) @(posedge pclk);
      check(64'(phase_code), (s == 2'h0) ? 64'h0 : 64'h5);
      target <= hi;
      wait_phase(4'h7);
      target <= stop - 16'h0001;
      repeat (3 * TK) @(posedge pclk);
      check(64'(final_ref_speed), 64'h0);
      target <= hi;
      repeat (3 * TK) @(posedge pclk);
      check(64'(phase_code), 64'h7);
      check(64'(final_ref_speed), 64'(hi));
      go <= 1'b0;
      wait_phase(4'h0);
      check(trace, exp_trace(m, s, t, z, d, ss));
      check(64'(output_on), 64'h0);
    end
    close_out();
  end
endmodule : test_drive_start_stop_sequencer
